// File: src/usb_port_router.v
// How it works
// - full/low-speed cores send words tagged only with 12 or 1.5 Mbit/s speed
// - high-speed core sends words tagged with the 480 Mbit/s speed
// - port control writes from full/low-speed cores blocked while high-speed owns port
// - high-speed-only status bits read as zero in full/low-speed views
// - ports one and three pair with core one, two and four with core two
// - four ports, each shared between high-speed core and its paired core
// - ownership follows the high-speed core's two control bits
// - after reset every port belongs to the full/low-speed cores
// - activity led pulses on enumeration traffic of its port
// - activity led pulses whenever a word for its port is passed to the transceiver while the port is not suspended
// - activity led stays off while its port is suspended
// - green and amber indicators follow software request, steady or blinking
// - every led is open drain: pulled low to light, released otherwise
// - functions 0 and 1 are the full/low-speed cores, function 2 high-speed
// - all functions master and target; interrupts merge onto one shared line
// - only function 0 gets legacy keyboard and mouse support
// - each function has own configuration select and own memory range
// - each function powers down on its own; powered-off function stays silent but still gets its configuration select
// - each core answers as target for accesses within its own range
// - each core may become bus master to reach system memory buffers
// - activity leds start off after reset
`timescale 1ns/100ps
`include "port_router_defines.vh"

module usb_port_router #(
  parameter LED_PULSE_CYC  = `LED_PULSE_MS * `CLK_KHZ,
  parameter BLINK_HALF_CYC = `BLINK_HALF_MS * `CLK_KHZ
) (
  input  wire        clk,
  input  wire        sys_rst,
  // ownership control from the high-speed core
  input  wire        ehciConfigFlag,
  input  wire [3:0]  ehciPortOwner,
  // traffic from the three cores
  input  wire        ehciTxValid,
  input  wire [7:0]  ehciTxData,
  input  wire [1:0]  ehciTxPort,
  output wire        ehciTxReady,
  input  wire        ohci1TxValid,
  input  wire [7:0]  ohci1TxData,
  input  wire        ohci1TxPort,
  input  wire        ohci1LowSpeed,
  output wire        ohci1TxReady,
  input  wire        ohci2TxValid,
  input  wire [7:0]  ohci2TxData,
  input  wire        ohci2TxPort,
  input  wire        ohci2LowSpeed,
  output wire        ohci2TxReady,
  // port control writes and status views
  input  wire        ohci1CtlWr,
  input  wire        ohci2CtlWr,
  input  wire [31:0] portStatus,
  output reg  [3:0]  portCtlWe,
  output reg  [3:0]  portOwnedByEhci,
  output reg  [7:0]  ohci1StatusView,
  output reg  [7:0]  ohci2StatusView,
  // transceiver side, paced by the link clock
  input  wire        usbClk,
  input  wire        phyReady,
  output reg         phyStrobe,
  output reg  [7:0]  phyData,
  output reg  [1:0]  phyPort,
  output reg  [1:0]  phySpeed,
  // leds
  input  wire [3:0]  portSuspend,
  input  wire [3:0]  greenReq,
  input  wire [3:0]  amberReq,
  input  wire [3:0]  blinkReq,
  output reg  [3:0]  linkLedOe,
  output wire [3:0]  linkLedOut,
  output reg  [3:0]  greenLedOe,
  output wire [3:0]  greenLedOut,
  output reg  [3:0]  amberLedOe,
  output wire [3:0]  amberLedOut,
  // bus function map
  input  wire [2:0]  funcIrq,
  input  wire [2:0]  funcPowerOff,
  output reg         intaOe,
  output wire        intaOut,
  input  wire        cfgValid,
  input  wire [2:0]  cfgFunc,
  output reg  [2:0]  cfgSelect,
  input  wire        legacyReq,
  output reg         legacyEnable,
  input  wire        tgtValid,
  input  wire [31:0] tgtAddr,
  input  wire [59:0] funcBase,
  output reg  [2:0]  tgtHit,
  input  wire [2:0]  masterReq,
  output reg  [2:0]  masterGnt
);

  // ----------------------------------------
  // open-drain pins: level is always low, enable lights the led or asserts the interrupt
  // ----------------------------------------
  assign linkLedOut  = 4'h0;
  assign greenLedOut = 4'h0;
  assign amberLedOut = 4'h0;
  assign intaOut     = 1'b0;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] usbClkSync_reg;
  reg [1:0] phyReadySync_reg;
  reg [3:0] suspMeta_reg;
  reg [3:0] suspSync_reg;

  // two flops before use; third stage of usbClk only feeds the edge finder
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usbClkSync_reg   <= 3'h0;
      phyReadySync_reg <= 2'h0;
      suspMeta_reg     <= 4'h0;
      suspSync_reg     <= 4'h0;
    end else begin
      usbClkSync_reg   <= {usbClkSync_reg[1:0], usbClk};
      phyReadySync_reg <= {phyReadySync_reg[0], phyReady};
      suspMeta_reg     <= portSuspend;
      suspSync_reg     <= suspMeta_reg;
    end
  end

  wire linkRise = usbClkSync_reg[1] & ~usbClkSync_reg[2];

  // ----------------------------------------
  // port ownership
  // ----------------------------------------
  reg  [3:0] ownEhci_reg;
  wire [3:0] ownEhci_next = ehciConfigFlag ? ~ehciPortOwner : 4'h0;

  // reset hands every port to the full/low-speed cores
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ownEhci_reg <= 4'h0;
    else
      ownEhci_reg <= ownEhci_next;
  end

  // ----------------------------------------
  // source arbitration into the buffer
  // ----------------------------------------
  // core one owns ports 0 and 2, core two owns ports 1 and 3
  wire [1:0] ohci1Port = {ohci1TxPort, 1'b0};
  wire [1:0] ohci2Port = {ohci2TxPort, 1'b1};
  wire ehciOk  = ownEhci_reg[ehciTxPort];
  wire ohci1Ok = ~ownEhci_reg[ohci1Port];
  wire ohci2Ok = ~ownEhci_reg[ohci2Port];

  reg  [1:0] fifoCnt_reg;
  reg  [1:0] fifoCnt_next;
  wire       fifoFull  = (fifoCnt_reg == 2'h2);
  wire       fifoEmpty = (fifoCnt_reg == 2'h0);

  // priority high-speed, then core one, then core two
  wire pickEhci  = ehciTxValid & ehciOk;
  wire pickOhci1 = ~pickEhci & ohci1TxValid & ohci1Ok;
  wire pickOhci2 = ~pickEhci & ~pickOhci1 & ohci2TxValid & ohci2Ok;
  wire push      = (pickEhci | pickOhci1 | pickOhci2) & ~fifoFull;

  // a word for a port the core does not own is swallowed, never stalls it
  assign ehciTxReady  = ~ehciOk | (pickEhci & ~fifoFull);
  assign ohci1TxReady = ~ohci1Ok | (pickOhci1 & ~fifoFull);
  assign ohci2TxReady = ~ohci2Ok | (pickOhci2 & ~fifoFull);

  reg [11:0] pushWord;
  always @* begin
    if (pickEhci)
      pushWord = {`SPEED_HS, ehciTxPort, ehciTxData};
    else if (pickOhci1)
      pushWord = {(ohci1LowSpeed ? `SPEED_LS : `SPEED_FS), ohci1Port, ohci1TxData};
    else
      pushWord = {(ohci2LowSpeed ? `SPEED_LS : `SPEED_FS), ohci2Port, ohci2TxData};
  end

  // ----------------------------------------
  // two-entry buffer, drained at most once per rising link clock edge
  // ----------------------------------------
  reg [11:0] fifoMem [0:1];
  reg        wrPtr_reg;
  reg        rdPtr_reg;
  wire       pop = linkRise & phyReadySync_reg[1] & ~fifoEmpty;

  always @* begin
    fifoCnt_next = fifoCnt_reg;
    if (push & ~pop)
      fifoCnt_next = fifoCnt_reg + 2'h1;
    else if (pop & ~push)
      fifoCnt_next = fifoCnt_reg - 2'h1;
  end

  // storage holds no reset, pointers and count do
  always @(posedge clk) begin
    if (push)
      fifoMem[wrPtr_reg] <= pushWord;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifoCnt_reg <= 2'h0;
      wrPtr_reg   <= 1'b0;
      rdPtr_reg   <= 1'b0;
      phyStrobe   <= 1'b0;
      phyData     <= 8'h00;
      phyPort     <= 2'h0;
      phySpeed    <= `SPEED_FS;
    end else begin
      fifoCnt_reg <= fifoCnt_next;
      if (push)
        wrPtr_reg <= ~wrPtr_reg;
      if (pop)
        rdPtr_reg <= ~rdPtr_reg;
      phyStrobe <= pop;
      if (pop) begin
        {phySpeed, phyPort, phyData} <= fifoMem[rdPtr_reg];
      end
    end
  end

  // ----------------------------------------
  // port control gating and status views
  // ----------------------------------------
  // write strobe aims at the port the core currently addresses with its tx port
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      portCtlWe       <= 4'h0;
      portOwnedByEhci <= 4'h0;
      ohci1StatusView <= 8'h00;
      ohci2StatusView <= 8'h00;
    end else begin
      portCtlWe <= (ohci1CtlWr & ohci1Ok ? (4'h1 << ohci1Port) : 4'h0)
                 | (ohci2CtlWr & ohci2Ok ? (4'h1 << ohci2Port) : 4'h0);
      portOwnedByEhci <= ownEhci_reg;
      ohci1StatusView <= portStatus[ohci1Port*8 +: 8] & ~`EHCI_ONLY_MASK;
      ohci2StatusView <= portStatus[ohci2Port*8 +: 8] & ~`EHCI_ONLY_MASK;
    end
  end

  // ----------------------------------------
  // activity leds
  // ----------------------------------------
  reg [`CNT_W-1:0] ledCnt_reg [0:3];
  reg [`CNT_W-1:0] blinkCnt_reg;
  reg              blinkPhase_reg;
  genvar p;

  // counter is long on purpose so a single short packet is still visible
  generate
    for (p = 0; p < `NPORT; p = p + 1) begin : g_led
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ledCnt_reg[p] <= {`CNT_W{1'b0}};
          linkLedOe[p]  <= 1'b0;
          greenLedOe[p] <= 1'b0;
          amberLedOe[p] <= 1'b0;
        end else begin
          if (suspSync_reg[p])
            ledCnt_reg[p] <= {`CNT_W{1'b0}};
          else if (pop & (fifoMem[rdPtr_reg][9:8] == p))
            ledCnt_reg[p] <= LED_PULSE_CYC[`CNT_W-1:0];
          else if (ledCnt_reg[p] != {`CNT_W{1'b0}})
            ledCnt_reg[p] <= ledCnt_reg[p] - 1'b1;
          linkLedOe[p]  <= ~suspSync_reg[p] & (ledCnt_reg[p] != {`CNT_W{1'b0}});
          greenLedOe[p] <= greenReq[p] & (~blinkReq[p] | blinkPhase_reg);
          amberLedOe[p] <= amberReq[p] & (~blinkReq[p] | blinkPhase_reg);
        end
      end
    end
  endgenerate

  // shared blink timebase keeps all blinking indicators in step
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blinkCnt_reg   <= {`CNT_W{1'b0}};
      blinkPhase_reg <= 1'b0;
    end else if (blinkCnt_reg == BLINK_HALF_CYC[`CNT_W-1:0] - 1'b1) begin
      blinkCnt_reg   <= {`CNT_W{1'b0}};
      blinkPhase_reg <= ~blinkPhase_reg;
    end else begin
      blinkCnt_reg <= blinkCnt_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // bus function map
  // ----------------------------------------
  wire [2:0] funcOn = ~funcPowerOff;
  reg  [2:0] hit;
  integer f;

  // compare upper address bits against each function's own range
  always @* begin
    hit = 3'h0;
    for (f = 0; f < 3; f = f + 1)
      hit[f] = tgtValid & funcOn[f] & (tgtAddr[31:12] == funcBase[f*`BASE_W +: `BASE_W]);
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intaOe       <= 1'b0;
      cfgSelect    <= 3'h0;
      legacyEnable <= 1'b0;
      tgtHit       <= 3'h0;
      masterGnt    <= 3'h0;
    end else begin
      intaOe <= |(funcIrq & funcOn);
      cfgSelect[0] <= cfgValid & (cfgFunc == `FUNC_OHCI1);
      cfgSelect[1] <= cfgValid & (cfgFunc == `FUNC_OHCI2);
      cfgSelect[2] <= cfgValid & (cfgFunc == `FUNC_EHCI);
      legacyEnable <= legacyReq & funcOn[0];
      tgtHit <= hit;
      // grant held while requested, otherwise fixed priority, high-speed first
      if (|(masterGnt & masterReq & funcOn))
        masterGnt <= masterGnt;
      else if (masterReq[2] & funcOn[2])
        masterGnt <= 3'h4;
      else if (masterReq[0] & funcOn[0])
        masterGnt <= 3'h1;
      else if (masterReq[1] & funcOn[1])
        masterGnt <= 3'h2;
      else
        masterGnt <= 3'h0;
    end
  end

endmodule

// File: src/port_router_defines.vh
`ifndef PORT_ROUTER_DEFINES_VH
`define PORT_ROUTER_DEFINES_VH

// ----------------------------------------
// clock and led timing
// ----------------------------------------
`define CLK_KHZ          25000
`define LED_PULSE_MS     50
`define BLINK_HALF_MS    500

// ----------------------------------------
// widths and codes
// ----------------------------------------
`define NPORT            4
`define DATA_W           8
`define CNT_W            24
`define SPEED_LS         2'h0
`define SPEED_FS         2'h1
`define SPEED_HS         2'h2
`define SRC_EHCI         2'h0
`define SRC_OHCI1        2'h1
`define SRC_OHCI2        2'h2
`define FUNC_OHCI1       3'h0
`define FUNC_OHCI2       3'h1
`define FUNC_EHCI        3'h2
// port status bits only the high-speed core uses, hidden from the others
`define EHCI_ONLY_MASK   8'hE0
`define BASE_W           20

`endif

// File: bench/port_router_asserts.sv
`timescale 1ns/100ps
// ------------------------------
// port router protocol checks
// ------------------------------
module port_router_asserts (
  input wire       clk,
  input wire       sys_rst,
  input wire       ehciConfigFlag,
  input wire [3:0] ehciPortOwner,
  input wire       ohci1CtlWr,
  input wire       ohci1TxPort,
  input wire [3:0] portCtlWe,
  input wire [3:0] portOwnedByEhci,
  input wire [7:0] ohci1StatusView,
  input wire [3:0] portSuspend,
  input wire [3:0] linkLedOe,
  input wire [2:0] funcIrq,
  input wire [2:0] funcPowerOff,
  input wire       intaOe,
  input wire [2:0] masterReq,
  input wire [2:0] masterGnt,
  input wire       phyStrobe,
  input wire [1:0] phyPort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ownership settles two cycles after steady control bits
  property p_own;
    (ehciConfigFlag && $stable(ehciPortOwner))[*3] |-> portOwnedByEhci == ~ehciPortOwner;
  endproperty
  a_own: assert property (p_own) else $error("ownership off");
  property p_rst_own;
    (!ehciConfigFlag)[*3] |-> portOwnedByEhci == 4'h0;
  endproperty
  a_rst_own: assert property (p_rst_own) else $error("ports not with companions");
  // owned state is checked twice so a fresh reset cannot fake it
  property p_ctl;
    ohci1CtlWr && !ohci1TxPort && portOwnedByEhci[0] && ehciConfigFlag && !ehciPortOwner[0]
      && $past(ehciConfigFlag && !ehciPortOwner[0]) |=> !portCtlWe[0];
  endproperty
  a_ctl: assert property (p_ctl) else $error("blocked write passed");
  property p_view;
    ohci1StatusView[7:5] == 3'h0;
  endproperty
  a_view: assert property (p_view) else $error("hidden bits visible");
  property p_susp;
    $stable(portSuspend)[*4] |-> (linkLedOe & portSuspend) == 4'h0;
  endproperty
  a_susp: assert property (p_susp) else $error("led lit in suspend");
  property p_led;
    phyStrobe && phyPort == 2'h0 && portSuspend == 4'h0 |=> (linkLedOe[0] || portSuspend[0])[*8];
  endproperty
  a_led: assert property (p_led) else $error("activity pulse missing");
  property p_inta;
    1'b1 |=> intaOe == |($past(funcIrq) & ~$past(funcPowerOff));
  endproperty
  a_inta: assert property (p_inta) else $error("shared interrupt wrong");
  property p_gnt;
    masterReq == 3'h4 && !funcPowerOff[2] |=> masterGnt == 3'h4;
  endproperty
  a_gnt: assert property (p_gnt) else $error("grant wrong");
  c_strobe: cover property (phyStrobe && phyPort == 2'h0);
  c_ctl: cover property (portCtlWe != 4'h0);
  c_inta: cover property (intaOe);
endmodule
bind usb_port_router port_router_asserts chk (.*);

// File: bench/usb_phy_model.sv
`timescale 1ns/100ps
// ------------------------------
// transceiver side model
// ------------------------------
module usb_phy_model (
  input  wire       clk,
  input  wire       run,
  input  wire       stall,
  input  wire       phyStrobe,
  input  wire [7:0] phyData,
  input  wire [1:0] phyPort,
  input  wire [1:0] phySpeed,
  output reg        usbClk,
  output reg        phyReady,
  output reg  [7:0] gotData,
  output reg  [3:0] gotTag,
  output reg  [7:0] gotCnt = 8'h00
);
  // link clock stands low outside frames; odd offset keeps it off the core edges
  initial begin
    usbClk = 1'b0;
    #7;
    forever #160 usbClk = run & ~usbClk;
  end
  always @* phyReady = !stall;
  // one word taken per strobe, kept for the bench to compare
  always @(posedge clk) begin
    if (phyStrobe) begin
      gotData <= phyData;
      gotTag  <= {phyPort, phySpeed};
      gotCnt  <= gotCnt + 8'h01;
    end
  end
endmodule

// File: bench/usb_port_router_tb.sv
`timescale 1ns/100ps
module usb_port_router_tb;
  reg        clk, sys_rst, run, stall, ehciConfigFlag, ehciTxValid, ohci1TxValid, ohci2TxValid, ohci1TxPort;
  reg        ohci2TxPort, ohci1LowSpeed, ohci2LowSpeed, ohci1CtlWr, ohci2CtlWr, cfgValid, legacyReq, tgtValid;
  reg  [1:0] ehciTxPort;
  reg  [2:0] funcIrq, funcPowerOff, cfgFunc, masterReq;
  reg  [3:0] ehciPortOwner, portSuspend, greenReq, amberReq, blinkReq;
  reg  [7:0] ehciTxData, ohci1TxData, ohci2TxData;
  reg [31:0] portStatus, tgtAddr;
  reg [59:0] funcBase;
  wire       usbClk, phyReady, phyStrobe, ehciTxReady, ohci1TxReady, ohci2TxReady, intaOe, intaOut, legacyEnable;
  wire [1:0] phyPort, phySpeed;
  wire [2:0] cfgSelect, tgtHit, masterGnt;
  wire [3:0] portCtlWe, portOwnedByEhci, linkLedOe, linkLedOut, greenLedOe, greenLedOut, amberLedOe, amberLedOut;
  wire [3:0] gotTag;
  wire [7:0] phyData, ohci1StatusView, ohci2StatusView, gotData, gotCnt;
  integer    n_fail, samples_checked, i, n;
  integer    cyc = 0;
  // short pulse and blink counts keep the run brief
  usb_port_router #(.LED_PULSE_CYC(20), .BLINK_HALF_CYC(16)) dut (.*);
  usb_phy_model phy (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  // ------------------------------
  // word push: mode 0 delivered, 1 dropped, 2 push only
  // ------------------------------
  task send(input [1:0] s, input [7:0] d, input [1:0] p, input [3:0] tag, input [1:0] mode);
    reg [7:0] c0;
    reg       r;
    begin
      c0 = gotCnt;
      run = 1'b1;
      {ehciTxValid, ohci1TxValid, ohci2TxValid} = 3'h4 >> s;
      {ehciTxData, ohci1TxData, ohci2TxData} = {3{d}};
      {ehciTxPort, ohci1TxPort, ohci2TxPort} = {p, p[0], p[0]};
      r = 1'b0;
      for (i = 0; i < 50 && !r; i = i + 1) begin
        #10 r = |({ehciTxReady, ohci1TxReady, ohci2TxReady} & (3'h4 >> s));
        @(posedge clk);
      end
      #1;
      {ehciTxValid, ohci1TxValid, ohci2TxValid} = 3'h0;
      if (mode != 2'h2) begin
        for (i = 0; i < 60 && gotCnt == c0; i = i + 1) #40;
        chk(gotCnt - c0, mode == 2'h0);
        if (mode == 2'h0) chk({gotTag, gotData}, {tag, d});
        run = 1'b0;
      end
    end
  endtask
  task t_route;
    begin
      send(2'h1, 8'hA5, 2'h1, 4'h9, 2'h0);
      ohci2LowSpeed = 1'b1;
      send(2'h2, 8'h3C, 2'h1, 4'hC, 2'h0);
      send(2'h0, 8'h11, 2'h0, 4'h0, 2'h1);
      ehciConfigFlag = 1'b1;
      ehciPortOwner = 4'hE;
      tick(3);
      chk(portOwnedByEhci, 4'h1);
      send(2'h0, 8'h5A, 2'h0, 4'h2, 2'h0);
      chk(linkLedOe, 4'h1);
      tick(18);
      chk(linkLedOe, 4'h1);
      tick(2);
      chk(linkLedOe, 4'h0);
      send(2'h1, 8'h77, 2'h0, 4'h0, 2'h1);
    end
  endtask
  task t_ctl;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        ohci1TxPort = i[0];
        ohci2TxPort = 1'b0;
        {ohci2CtlWr, ohci1CtlWr} = i == 2 ? 2'h2 : 2'h1;
        tick(1);
        {ohci2CtlWr, ohci1CtlWr} = 2'h0;
        chk(portCtlWe, i == 0 ? 4'h0 : i == 1 ? 4'h4 : 4'h2);
      end
      portStatus = 32'hFFFFFFFF;
      tick(2);
      chk({ohci1StatusView, ohci2StatusView}, 16'h1F1F);
    end
  endtask
  task t_susp_buf;
    reg [7:0] c0;
    begin
      portSuspend = 4'h1;
      tick(3);
      send(2'h0, 8'hC3, 2'h0, 4'h2, 2'h0);
      chk(linkLedOe, 4'h0);
      portSuspend = 4'h0;
      stall = 1'b1;
      tick(3);
      c0 = gotCnt;
      send(2'h0, 8'h01, 2'h0, 4'h0, 2'h2);
      tick(1);
      send(2'h0, 8'h02, 2'h0, 4'h0, 2'h2);
      tick(1);
      // full buffer stalls the owner, a word for a port it does not own is still swallowed
      {ehciTxValid, ohci1TxValid} = 2'h3;
      tick(4);
      chk({ehciTxReady, ohci1TxReady, ohci2TxReady}, 3'h2);
      {ehciTxValid, ohci1TxValid} = 2'h0;
      stall = 1'b0;
      for (i = 0; i < 80 && gotCnt != c0 + 8'h02; i = i + 1) #40;
      chk({gotCnt - c0, gotData}, 16'h0202);
      run = 1'b0;
    end
  endtask
  task t_ind_func;
    begin
      {greenReq, amberReq, blinkReq} = 12'h122;
      tick(1);
      chk(greenLedOe, 4'h1);
      chk({linkLedOut, greenLedOut, amberLedOut, intaOut}, 13'h0);
      n = 0;
      for (i = 0; i < 40; i = i + 1) begin
        n = n + amberLedOe[1];
        tick(1);
      end
      chk(n > 8 && n < 32, 1'b1);
      {funcIrq, funcPowerOff} = 6'h32;
      tick(1);
      chk(intaOe, 1'b1);
      funcIrq = 3'h2;
      tick(1);
      chk(intaOe, 1'b0);
      {funcPowerOff, legacyReq, cfgValid, tgtValid} = 6'h7;
      funcBase = {20'h3, 20'h2, 20'h1};
      for (i = 0; i < 3; i = i + 1) begin
        cfgFunc = i[2:0];
        tgtAddr = (i + 1) << 12;
        masterReq = 3'h1 << i;
        tick(1);
        chk({cfgSelect, tgtHit, masterGnt}, {3{3'h1 << i}});
      end
      chk(legacyEnable, 1'b1);
    end
  endtask
  initial begin
    {run, stall, ehciConfigFlag, ehciTxValid, ohci1TxValid, ohci2TxValid, ohci1TxPort, ohci2TxPort, ohci1LowSpeed,
     ohci2LowSpeed, ohci1CtlWr, ohci2CtlWr, cfgValid, legacyReq, tgtValid, ehciTxPort, funcIrq, funcPowerOff, cfgFunc,
     masterReq, ehciPortOwner, portSuspend, greenReq, amberReq, blinkReq, ehciTxData, ohci1TxData, ohci2TxData,
     portStatus, tgtAddr, funcBase} = '0;
    sys_rst = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    tick(8);
    sys_rst = 1'b0;
    tick(1);
    chk({portOwnedByEhci, linkLedOe, greenLedOe, amberLedOe}, 16'h0);
    t_route;
    t_ctl;
    t_susp_buf;
    t_ind_func;
    give_verdict;
  end
endmodule
